// ==== hdl/bfr_pkg.sv ====
// Constants for the bidirectional FIFO reset, flag and mailbox control block.
//
// Overview of operation
// - A reset ends only after four port-A and four port-B clock edges.
// - Reset inputs may change at any time; they are synchronised before use.
// - Reset returns the FIFO read and write pointers to empty.
// - During reset the FIFO's input-ready and output-ready flags are low.
// - Reset drives almost-empty low, almost-full high, mailbox flag high.
// - Reset clears the FIFO's mailbox new-mail indication.
// - Input-ready rises two write-port clock cycles after reset ends; port B's also waits until parallel offset loading is done.
// - The reset rising edge captures both offset-select inputs.
// - Mail flags fall on the writer's clock edge, rise on the reader's.
// - Data outputs are enabled only for the matching chip and direction selects.
// - Mailbox select combinationally puts the incoming mailbox on the data outputs.
// - A mailbox write shows on the far port's active outputs after the edge.
// - First port edge after reset samples fall-through select; high means standard.
// - Selects give offsets 64, 16, 8; both low at a FIFO1 reset means parallel programming, at a FIFO2 reset loads nothing.
// - With parallel programming, first four port-A writes load the offsets.
package bfr_pkg;
  localparam int          DATA_W      = 36;
  localparam int          OFS_W       = 16;
  localparam logic [2:0]  RST_EDGES   = 3'h4;
  localparam logic [1:0]  IR_DELAY    = 2'h2;
  localparam logic [OFS_W-1:0] OFS_SEL_HH = 16'h0040;
  localparam logic [OFS_W-1:0] OFS_SEL_HL = 16'h0010;
  localparam logic [OFS_W-1:0] OFS_SEL_LH = 16'h0008;
  localparam logic [2:0]  PROG_WORDS  = 3'h4;
  // Offset register slots in parallel load order.
  localparam int          IDX_Y1      = 0;
  localparam int          IDX_X1      = 1;
  localparam int          IDX_Y2      = 2;
  localparam int          IDX_X2      = 3;
  // Synchroniser lanes.
  localparam int          LN_PORT_A_CLOCK     = 0;
  localparam int          LN_PORT_B_CLOCK     = 1;
  localparam int          LN_FIFO1_RESET_N     = 2;
endpackage : bfr_pkg

// ==== hdl/bfr_core.sv ====
// Reset sequencing, flag initialisation, offset loading and mailboxes of a bidirectional FIFO.
`timescale 1ns/1ps
module bfr_core (
  input  wire logic                      mclk,
  input  wire logic                      reset,
  input  wire logic                      port_a_clock,
  input  wire logic                      port_b_clock,
  input  wire logic                      fifo1_reset_n,
  input  wire logic                      fifo2_reset_n,
  input  wire logic                      offset_select_lo,
  input  wire logic                      offset_select_hi,
  input  wire logic                      fall_through_select,
  input  wire logic                      port_a_chip_select_n,
  input  wire logic                      port_a_write_read_sel,
  input  wire logic                      port_a_enable,
  input  wire logic                      port_a_mailbox_select,
  input  wire logic [bfr_pkg::DATA_W-1:0] port_a_data_in,
  input  wire logic [bfr_pkg::DATA_W-1:0] port_a_fifo_word,
  output logic      [bfr_pkg::DATA_W-1:0] port_a_data_out,
  output logic                           port_a_data_oe_n,
  input  wire logic                      port_b_chip_select_n,
  input  wire logic                      port_b_write_read_sel,
  input  wire logic                      port_b_enable,
  input  wire logic                      port_b_mailbox_select,
  input  wire logic [bfr_pkg::DATA_W-1:0] port_b_data_in,
  input  wire logic [bfr_pkg::DATA_W-1:0] port_b_fifo_word,
  output logic      [bfr_pkg::DATA_W-1:0] port_b_data_out,
  output logic                           port_b_data_oe_n,
  output logic                           port_a_input_ready,
  output logic                           port_b_input_ready,
  output logic                           port_a_output_ready,
  output logic                           port_b_output_ready,
  output logic                           port_a_almost_empty_n,
  output logic                           port_b_almost_empty_n,
  output logic                           port_a_almost_full_n,
  output logic                           port_b_almost_full_n,
  output logic                           mail1_pending_n,
  output logic                           mail2_pending_n,
  output logic                           fifo1_standard_mode,
  output logic                           fifo2_standard_mode,
  output logic                           fifo1_in_reset,
  output logic                           fifo2_in_reset,
  output logic                           pointers_cleared,
  output logic      [bfr_pkg::OFS_W-1:0]  fifo1_empty_offset,
  output logic      [bfr_pkg::OFS_W-1:0]  fifo1_full_offset,
  output logic      [bfr_pkg::OFS_W-1:0]  fifo2_empty_offset,
  output logic      [bfr_pkg::OFS_W-1:0]  fifo2_full_offset,
  output logic                           offsets_loaded
);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // ------------------------------------------------------------------
  // Synchronisers
  // ------------------------------------------------------------------
  // Port clocks and resets are slow against mclk, so edges are found by sampling.
  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  logic [3:0] sync3_ff;
  logic       edge_a;
  logic       edge_b;
  logic [1:0] rst_low;
  logic [1:0] rst_rise;
  logic [1:0] wp_edge;

  always_ff @(posedge mclk) begin
    if (reset) begin
      sync1_ff <= 4'hF;
      sync2_ff <= 4'hF;
      sync3_ff <= 4'hF;
    end else begin
      sync1_ff <= {fifo2_reset_n, fifo1_reset_n, port_b_clock, port_a_clock};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  assign edge_a  = sync2_ff[bfr_pkg::LN_PORT_A_CLOCK] & ~sync3_ff[bfr_pkg::LN_PORT_A_CLOCK];
  assign edge_b  = sync2_ff[bfr_pkg::LN_PORT_B_CLOCK] & ~sync3_ff[bfr_pkg::LN_PORT_B_CLOCK];
  assign wp_edge = {edge_b, edge_a};

  // ------------------------------------------------------------------
  // Per-FIFO reset sequencing
  // ------------------------------------------------------------------
  logic [1:0] in_rst_ff;
  logic [1:0] mode_pend_ff;
  logic [1:0] std_mode_ff;
  logic [1:0] ir_ff;
  logic [1:0] or_ff;
  logic [1:0] ae_n_ff;
  logic [1:0] af_n_ff;
  logic [2:0] cnt_a_ff [2];
  logic [2:0] cnt_b_ff [2];
  logic [1:0] ir_cnt_ff [2];
  logic       prog_busy;

  for (genvar i = 0; i < 2; i++) begin : g_fifo
    logic       nxt_in_rst;
    logic       nxt_mode_pend;
    logic       nxt_std_mode;
    logic       nxt_ir;
    logic       nxt_or;
    logic       nxt_ae_n;
    logic       nxt_af_n;
    logic [2:0] nxt_cnt_a;
    logic [2:0] nxt_cnt_b;
    logic [1:0] nxt_ir_cnt;

    assign rst_low[i]  = ~sync2_ff[bfr_pkg::LN_FIFO1_RESET_N+i];
    assign rst_rise[i] = sync2_ff[bfr_pkg::LN_FIFO1_RESET_N+i] & ~sync3_ff[bfr_pkg::LN_FIFO1_RESET_N+i];

    always_comb begin
      nxt_cnt_a     = cnt_a_ff[i];
      nxt_cnt_b     = cnt_b_ff[i];
      nxt_in_rst    = in_rst_ff[i];
      nxt_mode_pend = mode_pend_ff[i];
      nxt_std_mode  = std_mode_ff[i];
      nxt_ir_cnt    = ir_cnt_ff[i];
      nxt_or        = or_ff[i];
      nxt_ae_n      = ae_n_ff[i];
      nxt_af_n      = af_n_ff[i];
      if (in_rst_ff[i]) begin
        // Edges count in both domains; the release waits for both tallies.
        if (edge_a && cnt_a_ff[i] < bfr_pkg::RST_EDGES) begin
          nxt_cnt_a = cnt_a_ff[i] + 3'h1;
        end
        if (edge_b && cnt_b_ff[i] < bfr_pkg::RST_EDGES) begin
          nxt_cnt_b = cnt_b_ff[i] + 3'h1;
        end
        if (!rst_low[i] && cnt_a_ff[i] >= bfr_pkg::RST_EDGES
            && cnt_b_ff[i] >= bfr_pkg::RST_EDGES) begin
          nxt_in_rst    = 1'b0;
          nxt_mode_pend = 1'b1;
        end
        nxt_ir_cnt = 2'h0;
        nxt_or     = 1'b0;
        nxt_ae_n   = 1'b0;
        nxt_af_n   = 1'b1;
      end else begin
        nxt_cnt_a = 3'h0;
        nxt_cnt_b = 3'h0;
        if (wp_edge[i] && ir_cnt_ff[i] < bfr_pkg::IR_DELAY) begin
          nxt_ir_cnt = ir_cnt_ff[i] + 2'h1;
        end
        if (mode_pend_ff[i] && wp_edge[i]) begin
          nxt_mode_pend = 1'b0;
          nxt_std_mode  = fall_through_select;
        end
      end
      if (rst_low[i]) begin
        nxt_in_rst = 1'b1;
      end
      nxt_ir = !nxt_in_rst && nxt_ir_cnt == bfr_pkg::IR_DELAY && !(i == 1 && prog_busy);
    end

    always_ff @(posedge mclk) begin
      if (reset) begin
        in_rst_ff[i]    <= 1'b1;
        mode_pend_ff[i] <= 1'b0;
        std_mode_ff[i]  <= 1'b1;
        ir_ff[i]        <= 1'b0;
        or_ff[i]        <= 1'b0;
        ae_n_ff[i]      <= 1'b0;
        af_n_ff[i]      <= 1'b1;
        cnt_a_ff[i]     <= 3'h0;
        cnt_b_ff[i]     <= 3'h0;
        ir_cnt_ff[i]    <= 2'h0;
      end else begin
        in_rst_ff[i]    <= nxt_in_rst;
        mode_pend_ff[i] <= nxt_mode_pend;
        std_mode_ff[i]  <= nxt_std_mode;
        ir_ff[i]        <= nxt_ir;
        or_ff[i]        <= nxt_or;
        ae_n_ff[i]      <= nxt_ae_n;
        af_n_ff[i]      <= nxt_af_n;
        cnt_a_ff[i]     <= nxt_cnt_a;
        cnt_b_ff[i]     <= nxt_cnt_b;
        ir_cnt_ff[i]    <= nxt_ir_cnt;
      end
    end
  end

  // Pointer logic lives with the memory; this level tells it to return to empty.
  assign pointers_cleared      = in_rst_ff[0] | in_rst_ff[1];
  assign fifo1_in_reset        = in_rst_ff[0];
  assign fifo2_in_reset        = in_rst_ff[1];
  assign port_a_input_ready    = ir_ff[0];
  assign port_b_input_ready    = ir_ff[1];
  assign port_b_output_ready   = or_ff[0];
  assign port_a_output_ready   = or_ff[1];
  assign port_b_almost_empty_n = ae_n_ff[0];
  assign port_a_almost_full_n  = af_n_ff[0];
  assign port_a_almost_empty_n = ae_n_ff[1];
  assign port_b_almost_full_n  = af_n_ff[1];
  assign fifo1_standard_mode   = std_mode_ff[0];
  assign fifo2_standard_mode   = std_mode_ff[1];

  // ------------------------------------------------------------------
  // Offsets and mailboxes
  // ------------------------------------------------------------------
  logic [bfr_pkg::OFS_W-1:0]  ofs_ff [4];
  logic [bfr_pkg::OFS_W-1:0]  nxt_ofs [4];
  logic [bfr_pkg::OFS_W-1:0]  preset;
  logic [2:0]                 prog_cnt_ff;
  logic [2:0]                 nxt_prog_cnt;
  logic [bfr_pkg::DATA_W-1:0] mail1_ff;
  logic [bfr_pkg::DATA_W-1:0] mail2_ff;
  logic [bfr_pkg::DATA_W-1:0] nxt_mail1;
  logic [bfr_pkg::DATA_W-1:0] nxt_mail2;
  logic                       mail1_pending_n_ff;
  logic                       mail2_pending_n_ff;
  logic                       nxt_mail1_pending_n;
  logic                       nxt_mail2_pending_n;
  logic                       a_write;
  logic                       a_read;
  logic                       b_write;
  logic                       b_read;

  assign a_write   = edge_a && !port_a_chip_select_n && port_a_write_read_sel && port_a_enable;
  assign a_read    = edge_a && !port_a_chip_select_n && !port_a_write_read_sel && port_a_enable;
  assign b_write   = edge_b && !port_b_chip_select_n && !port_b_write_read_sel && port_b_enable;
  assign b_read    = edge_b && !port_b_chip_select_n && port_b_write_read_sel && port_b_enable;
  assign prog_busy = prog_cnt_ff != bfr_pkg::PROG_WORDS;

  always_comb begin
    nxt_ofs      = ofs_ff;
    nxt_prog_cnt = prog_cnt_ff;
    nxt_mail1    = mail1_ff;
    nxt_mail2    = mail2_ff;
    nxt_mail1_pending_n     = mail1_pending_n_ff;
    nxt_mail2_pending_n     = mail2_pending_n_ff;
    if (offset_select_hi && offset_select_lo) begin
      preset = bfr_pkg::OFS_SEL_HH;
    end else if (offset_select_hi) begin
      preset = bfr_pkg::OFS_SEL_HL;
    end else begin
      preset = bfr_pkg::OFS_SEL_LH;
    end
    if (rst_rise[0]) begin
      if (offset_select_hi || offset_select_lo) begin
        nxt_ofs[bfr_pkg::IDX_Y1] = preset;
        nxt_ofs[bfr_pkg::IDX_X1] = preset;
      end else begin
        nxt_prog_cnt = 3'h0;
      end
    end
    if (rst_rise[1] && (offset_select_hi || offset_select_lo)) begin
      nxt_ofs[bfr_pkg::IDX_Y2] = preset;
      nxt_ofs[bfr_pkg::IDX_X2] = preset;
    end
    // Programming words bypass the memory while the load is pending.
    if (a_write && !port_a_mailbox_select && prog_busy && !in_rst_ff[0]
        && ir_ff[0]) begin
      nxt_ofs[prog_cnt_ff[1:0]] = port_a_data_in[bfr_pkg::OFS_W-1:0];
      nxt_prog_cnt = prog_cnt_ff + 3'h1;
    end
    // A read clears the flag, but a write in the same cycle wins.
    if (b_read && port_b_mailbox_select) begin
      nxt_mail1_pending_n = 1'b1;
    end
    if (a_write && port_a_mailbox_select) begin
      nxt_mail1 = port_a_data_in;
      nxt_mail1_pending_n  = 1'b0;
    end
    if (a_read && port_a_mailbox_select) begin
      nxt_mail2_pending_n = 1'b1;
    end
    if (b_write && port_b_mailbox_select) begin
      nxt_mail2 = port_b_data_in;
      nxt_mail2_pending_n  = 1'b0;
    end
    if (in_rst_ff[0]) begin
      nxt_mail1_pending_n = 1'b1;
    end
    if (in_rst_ff[1]) begin
      nxt_mail2_pending_n = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int k = 0; k < 4; k++) begin
        ofs_ff[k] <= '0;
      end
      prog_cnt_ff <= bfr_pkg::PROG_WORDS;
      mail1_ff    <= '0;
      mail2_ff    <= '0;
      mail1_pending_n_ff     <= 1'b1;
      mail2_pending_n_ff     <= 1'b1;
    end else begin
      ofs_ff      <= nxt_ofs;
      prog_cnt_ff <= nxt_prog_cnt;
      mail1_ff    <= nxt_mail1;
      mail2_ff    <= nxt_mail2;
      mail1_pending_n_ff     <= nxt_mail1_pending_n;
      mail2_pending_n_ff     <= nxt_mail2_pending_n;
    end
  end

  assign fifo1_full_offset  = ofs_ff[bfr_pkg::IDX_Y1];
  assign fifo1_empty_offset = ofs_ff[bfr_pkg::IDX_X1];
  assign fifo2_full_offset  = ofs_ff[bfr_pkg::IDX_Y2];
  assign fifo2_empty_offset = ofs_ff[bfr_pkg::IDX_X2];
  assign offsets_loaded     = !prog_busy;
  assign mail1_pending_n    = mail1_pending_n_ff;
  assign mail2_pending_n    = mail2_pending_n_ff;

  // ------------------------------------------------------------------
  // Data output steering
  // ------------------------------------------------------------------
  assign port_a_data_oe_n = port_a_chip_select_n | port_a_write_read_sel;
  assign port_b_data_oe_n = port_b_chip_select_n | ~port_b_write_read_sel;
  assign port_a_data_out  = port_a_mailbox_select ? mail2_ff : port_a_fifo_word;
  assign port_b_data_out  = port_b_mailbox_select ? mail1_ff : port_b_fifo_word;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  a_rst_edge_count: assert property ($fell(in_rst_ff[0]) |->
      $past(cnt_a_ff[0]) >= 3'h4 && $past(cnt_b_ff[0]) >= 3'h4)
    else $error("fifo1 reset ended before four edges per port");
  a_rst_ready_low: assert property (in_rst_ff[1] |=>
      !port_b_input_ready && !port_a_output_ready)
    else $error("fifo2 ready flags not low in reset");
  a_rst_flag_init: assert property (in_rst_ff[0] |=>
      !port_b_almost_empty_n && port_a_almost_full_n && mail1_pending_n)
    else $error("fifo1 reset flag values wrong");
  a_mail_clear_rst: assert property (in_rst_ff[1] |=> mail2_pending_n)
    else $error("mail2 flag not cleared by reset");
  a_ready_two_edges: assert property ($rose(port_a_input_ready) |->
      $past(ir_cnt_ff[0]) == 2'h1 && $past(edge_a) && !in_rst_ff[0])
    else $error("input ready rose without two port-A edges");
  a_mail_set_edge: assert property ($fell(mail1_pending_n) |->
      $past(edge_a) && $past(port_a_mailbox_select))
    else $error("mail1 flag fell off a port-A edge");
  a_mail_rel_edge: assert property ($rose(mail2_pending_n) |->
      $past(edge_a) || $past(in_rst_ff[1]))
    else $error("mail2 flag rose off a port-A edge");
  a_oe_b_dir: assert property (!port_b_data_oe_n |->
      !port_b_chip_select_n && port_b_write_read_sel)
    else $error("port B driven with wrong selects");
  a_mbx_through: assert property (a_write && port_a_mailbox_select
      && port_b_mailbox_select ##1 port_b_mailbox_select |->
      port_b_data_out == $past(port_a_data_in))
    else $error("mail1 word not on port B after write");
  a_mbx_select: assert property (port_a_mailbox_select |->
      port_a_data_out == mail2_ff)
    else $error("port A mailbox select not honoured");
  a_preset_64: assert property (rst_rise[0] && offset_select_hi && offset_select_lo |=>
      fifo1_full_offset == 16'h0040 && fifo1_empty_offset == 16'h0040)
    else $error("preset 64 not loaded for fifo1");
  a_prog_select: assert property (rst_rise[0] && !offset_select_hi && !offset_select_lo
      |=> !offsets_loaded)
    else $error("parallel programming not armed");
  a_prog_order: assert property (a_write && !port_a_mailbox_select && prog_cnt_ff == 3'h0
      && !in_rst_ff[0] && port_a_input_ready |=>
      fifo1_full_offset == $past(port_a_data_in[15:0]))
    else $error("first programming word not in fifo1 full offset");
  a_mode_sample: assert property (mode_pend_ff[0] && !in_rst_ff[0] && edge_a |=>
      fifo1_standard_mode == $past(fall_through_select))
    else $error("fall-through select not sampled");

endmodule : bfr_core

// ==== tb/bfr_port_ctl.sv ====
// Bus master model that drives both port clocks and both control sets of the FIFO block.
`timescale 1ns/1ps
module bfr_port_ctl (
  input  wire logic                       mclk,
  output logic                            port_a_clock,
  output logic                            port_b_clock,
  output logic                            port_a_chip_select_n,
  output logic                            port_a_write_read_sel,
  output logic                            port_a_enable,
  output logic                            port_a_mailbox_select,
  output logic [bfr_pkg::DATA_W-1:0]      port_a_data_in,
  output logic                            port_b_chip_select_n,
  output logic                            port_b_write_read_sel,
  output logic                            port_b_enable,
  output logic                            port_b_mailbox_select,
  output logic [bfr_pkg::DATA_W-1:0]      port_b_data_in
);
  // ----------------------------------------------------------------
  // Port clocks
  // ----------------------------------------------------------------
  // Both clocks run free, so reset edges keep being counted; levels last four or five mclk
  // so the block's edge detector never misses one, and the unequal rates keep phases apart.
  int cnt_a = 0;
  int cnt_b = 2;
  initial begin
    port_a_clock = 1'b0;
    port_b_clock = 1'b0;
    {port_a_chip_select_n, port_a_write_read_sel, port_a_enable, port_a_mailbox_select} = 4'h8;
    {port_b_chip_select_n, port_b_write_read_sel, port_b_enable, port_b_mailbox_select} = 4'h8;
    port_a_data_in = 36'h0;
    port_b_data_in = 36'h0;
  end
  always @(negedge mclk) begin
    cnt_a = (cnt_a == 3) ? 0 : cnt_a + 1;
    cnt_b = (cnt_b == 4) ? 0 : cnt_b + 1;
    if (cnt_a == 0) port_a_clock = ~port_a_clock;
    if (cnt_b == 0) port_b_clock = ~port_b_clock;
  end
  // ----------------------------------------------------------------
  // Port cycles
  // ----------------------------------------------------------------
  // Controls are {chip_select_n, write_read_sel, enable, mailbox_select}. They are set while
  // the port clock is low and held until the edge has been taken; afterwards enable drops and
  // the data lines show the inverse word, so stale data can never pass for a fresh write.
  task automatic a_cycle(input logic [3:0] ctl, input logic [35:0] d);
    @(negedge port_a_clock);
    @(negedge mclk);
    {port_a_chip_select_n, port_a_write_read_sel, port_a_enable, port_a_mailbox_select} = ctl;
    port_a_data_in = d;
    @(posedge port_a_clock);
    repeat (5) @(negedge mclk);
    port_a_enable = 1'b0;
    port_a_data_in = ~d;
  endtask : a_cycle
  task automatic b_cycle(input logic [3:0] ctl, input logic [35:0] d);
    @(negedge port_b_clock);
    @(negedge mclk);
    {port_b_chip_select_n, port_b_write_read_sel, port_b_enable, port_b_mailbox_select} = ctl;
    port_b_data_in = d;
    @(posedge port_b_clock);
    repeat (5) @(negedge mclk);
    port_b_enable = 1'b0;
    port_b_data_in = ~d;
  endtask : b_cycle
endmodule : bfr_port_ctl

// ==== tb/bfr_core_tb.sv ====
// Self-checking testbench for the bidirectional FIFO reset, flag and mailbox block.
`timescale 1ns/1ps
module bfr_core_tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [35:0] FW_A = 36'hA_AAAA_5555;
  localparam logic [35:0] FW_B = 36'h5_5555_AAAA;
  localparam logic [35:0] W1   = 36'h9_8765_4321;
  localparam logic [35:0] W2   = 36'h6_789A_BCDE;
  logic mclk, reset, fifo1_reset_n, fifo2_reset_n, offset_select_lo, offset_select_hi;
  logic fall_through_select, port_a_clock, port_b_clock, port_a_chip_select_n;
  logic port_a_write_read_sel, port_a_enable, port_a_mailbox_select, port_b_chip_select_n;
  logic port_b_write_read_sel, port_b_enable, port_b_mailbox_select;
  logic port_a_data_oe_n, port_b_data_oe_n, port_a_input_ready, port_b_input_ready;
  logic port_a_output_ready, port_b_output_ready, port_a_almost_empty_n, port_b_almost_empty_n;
  logic port_a_almost_full_n, port_b_almost_full_n, mail1_pending_n, mail2_pending_n;
  logic fifo1_standard_mode, fifo2_standard_mode, fifo1_in_reset, fifo2_in_reset;
  logic pointers_cleared, offsets_loaded;
  logic [bfr_pkg::DATA_W-1:0] port_a_data_in, port_b_data_in, port_a_data_out, port_b_data_out;
  logic [bfr_pkg::OFS_W-1:0]  fifo1_empty_offset, fifo1_full_offset;
  logic [bfr_pkg::OFS_W-1:0]  fifo2_empty_offset, fifo2_full_offset;
  int n_errors = 0;
  int comparisons = 0;
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  bfr_core u_dut (.mclk, .reset, .port_a_clock, .port_b_clock, .fifo1_reset_n, .fifo2_reset_n,
    .offset_select_lo, .offset_select_hi, .fall_through_select, .port_a_chip_select_n,
    .port_a_write_read_sel, .port_a_enable, .port_a_mailbox_select, .port_a_data_in,
    .port_a_fifo_word(FW_A), .port_a_data_out, .port_a_data_oe_n, .port_b_chip_select_n,
    .port_b_write_read_sel, .port_b_enable, .port_b_mailbox_select, .port_b_data_in,
    .port_b_fifo_word(FW_B), .port_b_data_out, .port_b_data_oe_n, .port_a_input_ready,
    .port_b_input_ready, .port_a_output_ready, .port_b_output_ready, .port_a_almost_empty_n,
    .port_b_almost_empty_n, .port_a_almost_full_n, .port_b_almost_full_n, .mail1_pending_n,
    .mail2_pending_n, .fifo1_standard_mode, .fifo2_standard_mode, .fifo1_in_reset,
    .fifo2_in_reset, .pointers_cleared, .fifo1_empty_offset, .fifo1_full_offset,
    .fifo2_empty_offset, .fifo2_full_offset, .offsets_loaded);
  bfr_port_ctl u_ctl (.mclk, .port_a_clock, .port_b_clock, .port_a_chip_select_n,
    .port_a_write_read_sel, .port_a_enable, .port_a_mailbox_select, .port_a_data_in,
    .port_b_chip_select_n, .port_b_write_read_sel, .port_b_enable, .port_b_mailbox_select,
    .port_b_data_in);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // The selects stay put until the next reset, so the capture at the rising edge is safe.
  task automatic pin_low(input logic [1:0] which, input logic [1:0] sel, input int n);
    @(negedge mclk);
    {offset_select_hi, offset_select_lo} = sel;
    fifo1_reset_n = ~which[1];
    fifo2_reset_n = ~which[0];
    repeat (n) @(posedge port_a_clock);
    repeat (n) @(posedge port_b_clock);
    @(negedge mclk);
  endtask : pin_low
  task automatic pin_high;
    fifo1_reset_n = 1'b1;
    fifo2_reset_n = 1'b1;
  endtask : pin_high
  task automatic wait_done(output int n);
    n = 0;
    while ((fifo1_in_reset | fifo2_in_reset) !== 1'b0 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    chk(n < 200, 1'b1);
  endtask : wait_done
  task automatic wait_ir_a(output int n);
    n = 0;
    while (port_a_input_ready !== 1'b1 && n < 40) begin
      @(negedge mclk);
      n++;
    end
    chk(n < 40, 1'b1);
  endtask : wait_ir_a
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_master;
    int n;
    fall_through_select = 1'b1;
    pin_low(2'h3, 2'h3, 5);
    chk({port_a_input_ready, port_b_input_ready, port_a_output_ready,
         port_b_output_ready}, 4'h0);
    chk({port_a_almost_empty_n, port_b_almost_empty_n, port_a_almost_full_n,
         port_b_almost_full_n}, 4'h3);
    chk({mail1_pending_n, mail2_pending_n, fifo1_in_reset, fifo2_in_reset,
         pointers_cleared}, 5'h1F);
    pin_high();
    wait_done(n);
    chk(port_a_input_ready, 1'b0);
    wait_ir_a(n);
    chk(n >= 6 && n <= 22, 1'b1);
    chk({fifo1_full_offset, fifo1_empty_offset, fifo2_full_offset, fifo2_empty_offset},
        {4{bfr_pkg::OFS_SEL_HH}});
    chk({fifo1_standard_mode, offsets_loaded}, 2'h3);
    repeat (30) @(negedge mclk);
    chk({port_b_input_ready, fifo2_standard_mode}, 2'h3);
  endtask : t_master
  // Released after only one edge per clock: the reset has to run on by itself.
  task automatic t_early;
    int n;
    pin_low(2'h1, 2'h2, 1);
    pin_high();
    repeat (3) @(negedge mclk);
    chk({fifo2_in_reset, fifo1_in_reset, port_a_input_ready}, 3'h5);
    wait_done(n);
    chk({fifo2_full_offset, fifo2_empty_offset, fifo1_full_offset},
        {{2{bfr_pkg::OFS_SEL_HL}}, bfr_pkg::OFS_SEL_HH});
    repeat (30) @(negedge mclk);
    chk(port_b_input_ready, 1'b1);
  endtask : t_early
  task automatic t_mail;
    for (int i = 0; i < 4; i++) begin
      u_ctl.a_cycle({i[1:0], 2'h1}, 36'h0);
      u_ctl.b_cycle({i[1:0], 2'h1}, 36'h0);
      chk({port_a_data_oe_n, port_b_data_oe_n}, {i != 0, i != 1});
    end
    u_ctl.b_cycle(4'h5, 36'h0);
    u_ctl.a_cycle(4'h7, W1);
    chk({mail1_pending_n, mail2_pending_n, port_b_data_oe_n, port_b_data_out},
        {3'h2, W1});
    repeat (20) @(negedge mclk);
    chk(mail1_pending_n, 1'b0);
    u_ctl.b_cycle(4'h7, 36'h0);
    chk(mail1_pending_n, 1'b1);
    u_ctl.a_cycle(4'h1, 36'h0);
    u_ctl.b_cycle(4'h3, W2);
    chk({mail2_pending_n, port_a_data_out}, {1'b0, W2});
    u_ctl.a_cycle(4'h0, 36'h0);
    chk(port_a_data_out, FW_A);
    u_ctl.a_cycle(4'h3, 36'h0);
    chk(mail2_pending_n, 1'b1);
  endtask : t_mail
  task automatic t_reset_mail;
    int n;
    u_ctl.a_cycle(4'h7, W1);
    chk(mail1_pending_n, 1'b0);
    fall_through_select = 1'b0;
    pin_low(2'h2, 2'h1, 5);
    chk({mail1_pending_n, port_a_input_ready, port_b_almost_empty_n, port_a_almost_full_n,
         pointers_cleared}, 5'h13);
    pin_high();
    wait_done(n);
    wait_ir_a(n);
    chk({fifo1_standard_mode, fifo1_full_offset, fifo1_empty_offset, fifo2_full_offset},
        {1'b0, {2{bfr_pkg::OFS_SEL_LH}}, bfr_pkg::OFS_SEL_HL});
  endtask : t_reset_mail
  task automatic t_parallel;
    int n;
    fall_through_select = 1'b1;
    pin_low(2'h3, 2'h0, 5);
    pin_high();
    wait_done(n);
    wait_ir_a(n);
    chk({offsets_loaded, port_b_input_ready}, 2'h0);
    for (int i = 1; i < 5; i++) begin
      u_ctl.a_cycle(4'h6, {20'hFFFFF, i[3:0], 12'h0A5});
    end
    chk({fifo1_full_offset, fifo1_empty_offset, fifo2_full_offset, fifo2_empty_offset},
        64'h10A5_20A5_30A5_40A5);
    repeat (30) @(negedge mclk);
    chk({offsets_loaded, port_b_input_ready}, 2'h3);
  endtask : t_parallel
  // ----------------------------------------------------------------
  // Sequence and verdict
  // ----------------------------------------------------------------
  task automatic wrap_up;
    $display("Mismatches %0d, comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up
  initial begin
    reset = 1'b1;
    fifo1_reset_n = 1'b1;
    fifo2_reset_n = 1'b1;
    offset_select_lo = 1'b1;
    offset_select_hi = 1'b1;
    fall_through_select = 1'b1;
    repeat (20) @(negedge mclk);
    chk({port_a_input_ready, mail1_pending_n, fifo1_in_reset, fifo2_in_reset}, 4'h7);
    reset = 1'b0;
    t_master();
    t_early();
    t_mail();
    t_reset_mail();
    t_parallel();
    wrap_up();
  end
  // The whole run takes about a thousand mclk; this limit of 12500 mclk is over ten times that.
  initial begin
    #100000;
    n_errors++;
    $display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    wrap_up();
  end
endmodule : bfr_core_tb
